//--- core/acc_transfer_alu_ops_defines.vh
// Purpose: Constants for the accumulator transfer and ALU datapath
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes:   Definitions only
`ifndef ACC_TRANSFER_ALU_OPS_DEFINES_VH
`define ACC_TRANSFER_ALU_OPS_DEFINES_VH

// ==========================================================
// Register word indices
`define IDX_OPCODE      4'h0
`define IDX_RF_FIRST    4'h1
`define IDX_RF_LAST     4'h8
`define IDX_FLAGS       4'h9
`define IDX_STATUS      4'ha

// ==========================================================
// Flag register bit positions
`define FLAG_CY_BIT     0
`define FLAG_P_BIT      2
`define FLAG_AC_BIT     4
`define FLAG_Z_BIT      6
`define FLAG_S_BIT      7

// ==========================================================
// Status register bit positions
`define STAT_ILLEGAL_BIT 0
`define STAT_UNSUPP_BIT  1

// ==========================================================
// Reset values
`define RST_BYTE        8'h00
`define RST_ADDR        16'h0000
`define RST_WORD        32'h0000_0000

// ==========================================================
// Operand field codes
`define CODE_B          3'h0
`define CODE_C          3'h1
`define CODE_D          3'h2
`define CODE_E          3'h3
`define CODE_H          3'h4
`define CODE_L          3'h5
`define CODE_MEM        3'h6
`define CODE_ACC        3'h7

// ==========================================================
// Opcode groups
`define GRP_MOVE        2'h1
`define GRP_ALU         2'h2
`define GRP_INDIRECT    2'h0
`define IND_LOW_BITS    3'h2
`define ALU_ADD         3'h0
`define ALU_ADC         3'h1
`define ALU_SUB         3'h2
`define ALU_SUB_BORROW  3'h3
`define ALU_AND         3'h4
`define ALU_XOR         3'h5
`define ALU_OR          3'h6
`define ALU_COMPARE     3'h7

`endif

//--- core/acc_transfer_alu_ops.v
// Purpose: Executes register moves, indirect accumulator store/load and
//          the eight accumulator operations, with flag update
// Assumes: Memory logic runs on REF_CLK_I; MEM_ACK_I is a same-clock pulse
// Notes:   Writing the opcode word executes it; the bus write completes
//          only when execution, including any memory access, is done
`timescale 1ns/1ps
`default_nettype none
`include "acc_transfer_alu_ops_defines.vh"

// Summary of operation
// RULE1 - Move copies source field operand to destination, source and flags untouched.
// RULE2 - Operand codes: B,C,D,E,H,L as 000..101, memory 110, accumulator 111.
// RULE3 - Software never issues a move with both fields set to memory.
// RULE4 - Store indirect writes accumulator at BC (bit4=0) or DE (bit4=1).
// RULE5 - Load indirect loads accumulator from BC or DE address, flags unchanged.
// RULE6 - Add puts accumulator plus operand into accumulator, updates five flags.
// RULE7 - Addition carry flag equals the ninth result bit.
// RULE8 - Add with carry also adds the current carry flag.
// RULE9 - Subtract uses two's complement; carry set when no carry-out occurs.
// RULE10 - Subtract with borrow removes operand plus carry from accumulator.
// RULE11 - AND into accumulator clears carry, updates zero, sign and parity.
// RULE12 - XOR into accumulator clears carry, updates sign, zero and parity.
// RULE13 - OR into accumulator clears carry, updates zero, sign and parity.
// RULE14 - Compare subtracts only for flags; accumulator and operand stay unchanged.
// RULE15 - Compare: zero on equality, carry when operand exceeds accumulator.
// RULE16 - Compare carry sense reverses when the two bytes differ in sign.
// RULE17 - Memory operand code addresses memory through the H,L pair.
// RULE18 - Compare decodes from pattern 10 111 plus operand field.
// RULE19 - Sign is bit 7, zero on zero result, even parity, carry out of bit 3.
module acc_transfer_alu_ops #(
  parameter ADDR_W = 4
) (
  input  wire              REF_CLK_I,
  input  wire              RST_I,
  input  wire [ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire              AVS_READ_I,
  input  wire              AVS_WRITE_I,
  input  wire [31:0]       AVS_WRITEDATA_I,
  output reg  [31:0]       AVS_READDATA_O,
  output reg               AVS_WAITREQUEST_O,
  output reg               MEM_REQ_O,
  output reg               MEM_WE_O,
  output reg  [15:0]       MEM_ADDR_O,
  output reg  [7:0]        MEM_WDATA_O,
  input  wire [7:0]        MEM_RDATA_I,
  input  wire              MEM_ACK_I
);

  // ========================================================
  // States
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_MEM  = 3'b010;
  localparam [2:0] S_ANS  = 3'b100;

  reg  [2:0] state_q;
  reg  [7:0] rf_q [0:7];
  reg  [7:0] op_q;
  reg        cy_q;
  reg        p_q;
  reg        ac_q;
  reg        z_q;
  reg        s_q;
  reg        illegal_q;
  reg        unsupp_q;
  integer    i;

  // ========================================================
  // Helpers
  function parity_even;
    input [7:0] v;
    begin
      parity_even = ~^v;
    end
  endfunction

  function [15:0] pair;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair = {hi, lo};
    end
  endfunction

  function in_rf_window;
    input [3:0] idx;
    begin
      in_rf_window = (idx >= `IDX_RF_FIRST) && (idx <= `IDX_RF_LAST);
    end
  endfunction

  // ========================================================
  // Decode
  // Stored opcode drives decode while memory is busy, so the result never
  // depends on how long the master keeps its write data up
  wire [7:0] cur_op   = (state_q == S_MEM) ? op_q : AVS_WRITEDATA_I[7:0];
  wire [2:0] dst      = cur_op[5:3];
  wire [2:0] src      = cur_op[2:0];
  wire       is_move  = (cur_op[7:6] == `GRP_MOVE);
  wire       is_alu   = (cur_op[7:6] == `GRP_ALU);
  wire       is_ind   = (cur_op[7:6] == `GRP_INDIRECT) && !cur_op[5] && (cur_op[2:0] == `IND_LOW_BITS);
  wire       is_store_ind = is_ind && !cur_op[3];
  wire       is_load_ind  = is_ind && cur_op[3];
  wire       src_mem  = (src == `CODE_MEM);                                  // RULE2
  wire       dst_mem  = (dst == `CODE_MEM);
  wire       illegal  = is_move && src_mem && dst_mem;                       // RULE3
  wire       need_rd  = (is_move && src_mem && !dst_mem) || is_load_ind || (is_alu && src_mem);
  wire       need_wr  = (is_move && dst_mem && !src_mem) || is_store_ind;
  wire [15:0] hl_addr = pair(rf_q[`CODE_H], rf_q[`CODE_L]);                  // RULE17
  wire [15:0] bc_addr = pair(rf_q[`CODE_B], rf_q[`CODE_C]);
  wire [15:0] de_addr = pair(rf_q[`CODE_D], rf_q[`CODE_E]);
  wire [15:0] ind_addr = cur_op[4] ? de_addr : bc_addr;                      // RULE4 RULE5
  wire [15:0] mem_addr = is_ind ? ind_addr : hl_addr;
  wire [7:0]  mem_wdat = is_store_ind ? rf_q[`CODE_ACC] : rf_q[src];
  // Memory data is valid only in the ack cycle and is consumed right there
  wire [7:0]  operand  = src_mem ? MEM_RDATA_I : rf_q[src];

  // ========================================================
  // Execute
  reg        ex_we;
  reg  [2:0] ex_idx;
  reg  [7:0] ex_val;
  reg        cy_d;
  reg        p_d;
  reg        ac_d;
  reg        z_d;
  reg        s_d;
  reg        is_sub;
  reg        use_c;
  reg        c_in;
  reg  [7:0] x_eff;
  reg  [8:0] sum9;
  reg  [4:0] lo5;
  reg  [7:0] res;
  reg  [7:0] acc;

  always @* begin
    ex_we  = 1'b0;
    ex_idx = dst;
    ex_val = operand;
    cy_d   = cy_q;
    p_d    = p_q;
    ac_d   = ac_q;
    z_d    = z_q;
    s_d    = s_q;
    acc    = rf_q[`CODE_ACC];
    is_sub = (dst == `ALU_SUB) || (dst == `ALU_SUB_BORROW) || (dst == `ALU_COMPARE);
    use_c  = (dst == `ALU_ADC) || (dst == `ALU_SUB_BORROW);                    // RULE8 RULE10
    x_eff  = is_sub ? ~operand : operand;                                     // RULE9
    c_in   = is_sub ? ~(use_c & cy_q) : (use_c & cy_q);
    sum9   = {1'b0, acc} + {1'b0, x_eff} + {8'h00, c_in};
    lo5    = {1'b0, acc[3:0]} + {1'b0, x_eff[3:0]} + {4'h0, c_in};
    res    = sum9[7:0];
    if (is_move) begin
      ex_we  = !dst_mem;                                                      // RULE1
      ex_val = operand;
    end else if (is_load_ind) begin
      ex_we  = 1'b1;                                                          // RULE5
      ex_idx = `CODE_ACC;
      ex_val = MEM_RDATA_I;
    end else if (is_alu) begin
      case (dst)
        `ALU_AND: res = acc & operand;                                        // RULE11
        `ALU_XOR: res = acc ^ operand;                                        // RULE12
        `ALU_OR:  res = acc | operand;                                        // RULE13
        default:  res = sum9[7:0];                                            // RULE6
      endcase
      ex_we  = (dst != `ALU_COMPARE);                                         // RULE14 RULE18
      ex_idx = `CODE_ACC;
      ex_val = res;
      s_d    = res[7];                                                        // RULE19
      z_d    = (res == 8'h00);                                                // RULE15
      p_d    = parity_even(res);
      // Logic ops and compare keep aux carry; only add and subtract define it
      if (dst[2] && (dst != `ALU_COMPARE)) begin
        cy_d = 1'b0;                                                          // RULE11 RULE12 RULE13
      end else if (dst == `ALU_COMPARE) begin
        // A sign mismatch flips the borrow, so carry orders signed bytes
        cy_d = ~sum9[8] ^ (acc[7] ^ operand[7]);                              // RULE15 RULE16
      end else begin
        cy_d = is_sub ? ~sum9[8] : sum9[8];                                   // RULE7 RULE9
        ac_d = lo5[4];                                                        // RULE19
      end
    end
  end

  // ========================================================
  // Register read mux
  reg [31:0] rd_word;
  reg [3:0]  ridx;

  always @* begin
    ridx    = AVS_ADDRESS_I[3:0] - `IDX_RF_FIRST;
    rd_word = `RST_WORD;
    if (AVS_ADDRESS_I == `IDX_OPCODE) begin
      rd_word = {24'h000000, op_q};
    end else if (in_rf_window(AVS_ADDRESS_I[3:0])) begin
      rd_word = {24'h000000, rf_q[ridx[2:0]]};
    end else if (AVS_ADDRESS_I == `IDX_FLAGS) begin
      rd_word[`FLAG_CY_BIT] = cy_q;
      rd_word[`FLAG_P_BIT]  = p_q;
      rd_word[`FLAG_AC_BIT] = ac_q;
      rd_word[`FLAG_Z_BIT]  = z_q;
      rd_word[`FLAG_S_BIT]  = s_q;
    end else if (AVS_ADDRESS_I == `IDX_STATUS) begin
      rd_word[`STAT_ILLEGAL_BIT] = illegal_q;
      rd_word[`STAT_UNSUPP_BIT]  = unsupp_q;
    end
  end

  // ========================================================
  // Sequencer and bus slave
  // Waitrequest rests high; one low cycle answers each request, so a held
  // request is never taken twice.
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q           <= S_IDLE;
      op_q              <= `RST_BYTE;
      cy_q              <= 1'b0;
      p_q               <= 1'b0;
      ac_q              <= 1'b0;
      z_q               <= 1'b0;
      s_q               <= 1'b0;
      illegal_q         <= 1'b0;
      unsupp_q          <= 1'b0;
      AVS_READDATA_O    <= `RST_WORD;
      AVS_WAITREQUEST_O <= 1'b1;
      MEM_REQ_O         <= 1'b0;
      MEM_WE_O          <= 1'b0;
      MEM_ADDR_O        <= `RST_ADDR;
      MEM_WDATA_O       <= `RST_BYTE;
      for (i = 0; i < 8; i = i + 1) begin
        rf_q[i] <= `RST_BYTE;
      end
    end else begin
      case (state_q)
        S_IDLE: begin
          if (AVS_READ_I) begin
            AVS_READDATA_O    <= rd_word;
            AVS_WAITREQUEST_O <= 1'b0;
            state_q           <= S_ANS;
          end else if (AVS_WRITE_I) begin
            if (AVS_ADDRESS_I == `IDX_OPCODE) begin
              op_q      <= AVS_WRITEDATA_I[7:0];
              illegal_q <= illegal;
              unsupp_q  <= !(is_move || is_alu || is_ind);
              // Answered at once; register file and flags stay as they were, only opcode and status words change
              if (illegal) begin
                AVS_WAITREQUEST_O <= 1'b0;                                    // RULE3
                state_q           <= S_ANS;
              end else if (need_rd || need_wr) begin
                MEM_REQ_O   <= 1'b1;                                          // RULE17
                MEM_WE_O    <= need_wr;
                MEM_ADDR_O  <= mem_addr;
                MEM_WDATA_O <= mem_wdat;                                      // RULE4
                state_q     <= S_MEM;
              end else begin
                if (ex_we) begin
                  rf_q[ex_idx] <= ex_val;
                end
                cy_q              <= cy_d;
                p_q               <= p_d;
                ac_q              <= ac_d;
                z_q               <= z_d;
                s_q               <= s_d;
                AVS_WAITREQUEST_O <= 1'b0;
                state_q           <= S_ANS;
              end
            end else begin
              // Slot 6 (word 7) stands for the memory code and has no storage behind it
              if (in_rf_window(AVS_ADDRESS_I[3:0]) && ridx[2:0] != `CODE_MEM) begin
                rf_q[ridx[2:0]] <= AVS_WRITEDATA_I[7:0];
              end
              if (AVS_ADDRESS_I == `IDX_FLAGS) begin
                cy_q <= AVS_WRITEDATA_I[`FLAG_CY_BIT];
                p_q  <= AVS_WRITEDATA_I[`FLAG_P_BIT];
                ac_q <= AVS_WRITEDATA_I[`FLAG_AC_BIT];
                z_q  <= AVS_WRITEDATA_I[`FLAG_Z_BIT];
                s_q  <= AVS_WRITEDATA_I[`FLAG_S_BIT];
              end
              AVS_WAITREQUEST_O <= 1'b0;
              state_q           <= S_ANS;
            end
          end
        end
        S_MEM: begin
          // No timeout: a memory that never answers stalls the bus
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WE_O  <= 1'b0;
            if (!MEM_WE_O) begin
              if (ex_we) begin
                rf_q[ex_idx] <= ex_val;
              end
              cy_q <= cy_d;
              p_q  <= p_d;
              ac_q <= ac_d;
              z_q  <= z_d;
              s_q  <= s_d;
            end
            AVS_WAITREQUEST_O <= 1'b0;
            state_q           <= S_ANS;
          end
        end
        S_ANS: begin
          AVS_WAITREQUEST_O <= 1'b1;
          state_q           <= S_IDLE;
        end
        default: begin
          AVS_WAITREQUEST_O <= 1'b1;
          MEM_REQ_O         <= 1'b0;
          state_q           <= S_IDLE;
        end
      endcase
    end
  end

endmodule // acc_transfer_alu_ops
`default_nettype wire

//--- test/acc_transfer_alu_ops_sva.sv
// Purpose: Port checker for the accumulator datapath
// Assumes: One clock, synchronous reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module acc_transfer_alu_ops_sva #(
  parameter ADDR_W = 4
) (
  input wire logic              REF_CLK_I,
  input wire logic              RST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic              AVS_READ_I,
  input wire logic              AVS_WRITE_I,
  input wire logic [31:0]       AVS_WRITEDATA_I,
  input wire logic [31:0]       AVS_READDATA_O,
  input wire logic              AVS_WAITREQUEST_O,
  input wire logic              MEM_REQ_O,
  input wire logic              MEM_WE_O,
  input wire logic [15:0]       MEM_ADDR_O,
  input wire logic [7:0]        MEM_WDATA_O,
  input wire logic [7:0]        MEM_RDATA_I,
  input wire logic              MEM_ACK_I
);
  // ==========================================
  // Helper: opcode seen one edge ago
  logic [7:0] op_q;
  always @(posedge REF_CLK_I) op_q <= AVS_WRITEDATA_I[7:0];
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  // ==========================================
  // Assertions
  a_req_from_opcode: assert property ($rose(MEM_REQ_O) |-> $past(AVS_WRITE_I) && $past(AVS_ADDRESS_I) == 0)
    else $error("memory access without opcode write");
  a_mem_direction: assert property ($rose(MEM_REQ_O) |-> MEM_WE_O ==
    ((op_q[7:6] == 2'h1 && op_q[5:3] == 3'h6) || (op_q[7:6] == 2'h0 && !op_q[3])))
    else $error("memory direction wrong");
  a_req_holds: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
    && $stable(MEM_WE_O) && $stable(MEM_WDATA_O)) else $error("memory request changed early");
  a_req_ends: assert property (MEM_REQ_O && MEM_ACK_I |=> !MEM_REQ_O && !AVS_WAITREQUEST_O)
    else $error("access not closed after ack");
  a_wait_in_access: assert property (MEM_REQ_O |-> AVS_WAITREQUEST_O)
    else $error("answer during memory access");
  a_read_quick: assert property ($rose(AVS_READ_I) |=> !AVS_WAITREQUEST_O)
    else $error("read not answered next cycle");
  a_byte_lane: assert property (AVS_READ_I && !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
    else $error("upper read bits set");
  a_answer_once: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer longer than one cycle");
  a_move_no_mem: assert property ($rose(AVS_WRITE_I) && AVS_ADDRESS_I == 0 && AVS_WRITEDATA_I[7:6] == 2'h1
    && AVS_WRITEDATA_I[5:3] != 3'h6 && AVS_WRITEDATA_I[2:0] != 3'h6 |=> !MEM_REQ_O && !AVS_WAITREQUEST_O)
    else $error("register move not done in one cycle");
endmodule // acc_transfer_alu_ops_sva
bind acc_transfer_alu_ops acc_transfer_alu_ops_sva #(.ADDR_W(ADDR_W)) u_sva (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I));
`default_nettype wire

//--- test/acc_transfer_alu_ops_mem.sv
// Purpose: Byte memory model on the far side of the datapath
// Assumes: Same clock, one access at a time
// Notes:   Answers after 0 to 3 idle cycles
`timescale 1ns/1ps
`default_nettype none
module acc_transfer_alu_ops_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output var  logic [7:0]  rdata_o,
  output var  logic        ack_o
);
  logic [7:0] m[int];
  initial begin
    rdata_o = 8'h00;
    ack_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (req_i === 1'b1 && rst_i === 1'b0) begin
        repeat ($urandom % 4) begin
          rdata_o <= $urandom;
          @(posedge clk_i);
        end
        if (we_i) m[addr_i] = wdata_i;
        rdata_o <= m.exists(addr_i) ? m[addr_i] : addr_i[7:0] ^ addr_i[15:8];
        ack_o <= 1'b1;
        @(posedge clk_i);
        ack_o <= 1'b0;
        rdata_o <= $urandom;
      end else begin
        // Data outside the ack cycle is noise, so a late sample shows
        rdata_o <= $urandom;
      end
    end
  end
endmodule // acc_transfer_alu_ops_mem
`default_nettype wire

//--- test/acc_transfer_alu_ops_tb.sv
// Purpose: Self-checking bench for the accumulator datapath
// Assumes: Memory model answers every request
// Notes:   Full register dump after every opcode
`timescale 1ns/1ps
`default_nettype none
module acc_transfer_alu_ops_tb;
  logic        clk = 0;
  logic        rst = 1;
  logic        rd = 0;
  logic        wr = 0;
  logic [3:0]  adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rdat;
  logic        wt, mreq, mwe, mack;
  logic [15:0] maddr;
  logic [7:0]  mwd, mrd, f = 0, lastop = 0;
  logic [7:0]  r[8] = '{default: 8'h00};
  logic [1:0]  st = 0;
  logic [7:0]  m[int];
  logic [31:0] eq[$], mq[$];
  logic [23:0] wq[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  always #2 clk = ~clk;
  acc_transfer_alu_ops dut (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .MEM_REQ_O(mreq),
    .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .MEM_ACK_I(mack));
  acc_transfer_alu_ops_mem mem (.clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwd), .rdata_o(mrd), .ack_o(mack));
  // ==========================================
  // Bus and model tasks
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
      if (n > 500) begin
        n_errors++;
        give_verdict();
      end
    end while (wt !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic [7:0] mget(input logic [15:0] a);
    return m.exists(a) ? m[a] : a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [7:0] rv();
    logic [9:0] v;
    v = $urandom;
    // Bias towards the carry and sign boundaries
    return v[9:8] == 0 ? {v[1], {7{v[0]}}} : v[7:0];
  endfunction
  task automatic setr(input int i, input logic [7:0] v);
    bus(1'b1, i[3:0], {$urandom} << 8 | v);
    if (i > 0 && i < 9 && i != 7) r[i-1] = v;
    if (i == 9) f = v;
  endtask
  task automatic check_all();
    logic [31:0] e;
    for (int i = 0; i < 16; i++) begin
      e = i == 0 ? lastop : i == 9 ? f : i == 10 ? st : 0;
      if (i > 0 && i < 9 && i != 7) e = r[i-1];
      eq.push_back(e);
      mq.push_back(i == 9 ? 32'h0000_00d5 : 32'hffff_ffff);
      bus(1'b0, i[3:0], 32'h0);
    end
  endtask
  task automatic exec(input logic [7:0] o);
    logic [7:0]  s, a, x;
    logic [8:0]  t;
    logic [4:0]  h;
    logic        b, ci, cy, ac;
    logic [15:0] p;
    lastop = o;
    a = r[7];
    b = o[3] & f[0] & ~o[5];
    p = {r[4], r[5]};
    s = o[2:0] == 3'h6 ? mget(p) : r[o[2:0]];
    st = (o[7:6] == 2'h3 || (o[7:6] == 2'h0 && (o[2:0] != 3'h2 || o[5]))) ? 2'h2 : 2'h0;
    if (o == 8'h76) st = 2'h1;
    else if (o[7:6] == 2'h1 && o[5:3] == 3'h6) begin
      m[p] = s;
      wq.push_back({p, s});
    end else if (o[7:6] == 2'h1) r[o[5:3]] = s;
    else if (st == 0 && o[7:6] == 2'h0) begin
      p = o[4] ? {r[2], r[3]} : {r[0], r[1]};
      if (o[3]) r[7] = mget(p);
      else begin
        m[p] = r[7];
        wq.push_back({p, r[7]});
      end
    end else if (o[7:6] == 2'h2) begin
      x = o[4] ? ~s : s;
      ci = o[4] ^ b;
      t = a + x + ci;
      h = a[3:0] + x[3:0] + ci;
      ac = o[5] ? f[4] : h[4];
      cy = o[5] ? (t[8] ^ 1'b1 ^ a[7] ^ s[7]) : t[8] ^ o[4];
      if (o[5] && o[5:3] != 3'h7) begin
        cy = 1'b0;
        t = o[4:3] == 2'h0 ? a & s : o[3] ? a ^ s : a | s;
      end
      f = {t[7], t[7:0] == 8'h00, 1'b0, ac, 1'b0, ~^t[7:0], 1'b0, cy};
      if (o[5:3] != 3'h7) r[7] = t[7:0];
    end
    bus(1'b1, 4'h0, {24'h0, o});
    samples_checked++;
    if (wq.size() != 0) begin
      n_errors++;
      $display("CHECK FAILED memory writes pending expected 0 seen %0d", wq.size());
      wq.delete();
    end
  endtask
  // ==========================================
  // Result monitor
  always @(posedge clk) begin
    if (rd === 1'b1 && wt === 1'b0) begin
      samples_checked++;
      if ((rdat & mq[0]) !== (eq[0] & mq[0])) begin
        n_errors++;
        $display("CHECK FAILED index %0d expected %h seen %h", adr, eq[0] & mq[0], rdat & mq[0]);
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    if (mreq === 1'b1 && mack === 1'b1 && mwe === 1'b1) begin
      samples_checked++;
      if ({maddr, mwd} !== wq[0]) begin
        n_errors++;
        $display("CHECK FAILED memory write expected %h seen %h", wq[0], {maddr, mwd});
      end
      void'(wq.pop_front());
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] o;
    void'($urandom(32'h4de8d049));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check_all();
    for (int k = 0; k < 340; k++) begin
      for (int i = 1; i < 16; i++) if (i != 10) setr(i, rv());
      o = k < 128 ? 8'h40 + k[7:0] : k < 136 ? {3'h0, k[1:0], 3'h2} : rv();
      if (o == 8'h76) o = 8'h77;
      exec(o);
      check_all();
    end
    give_verdict();
  end
  initial begin
    #400_000;
    n_errors++;
    give_verdict();
  end
endmodule // acc_transfer_alu_ops_tb
`default_nettype wire
